// >>> logic/dsp_pkg.sv
`default_nettype none
package dsp_pkg;
    localparam int NARROW_W = 9;
    localparam int CLK_SRC_N = 4;
    localparam int SEL_W = 2;
    localparam int CTL_W = 4;
    localparam int CTL_SA = 0;
    localparam int CTL_SB = 1;
    localparam int CTL_AS01 = 2;
    localparam int CTL_AS23 = 3;
    localparam logic RESET_BIT = 1'b0;

    typedef enum logic [2:0] {
        WIDTH_WIDE   = 3'b001,
        WIDTH_MID    = 3'b010,
        WIDTH_NARROW = 3'b100
    } width_mode_t;
endpackage
`default_nettype wire

// >>> logic/dsp_multiply_add_slice.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_multiply_add_slice #(
    parameter  int NARROW_W = dsp_pkg::NARROW_W,
    localparam int MID_W    = 2 * NARROW_W,
    localparam int WIDE_W   = 4 * NARROW_W,
    localparam int OP_W     = 8 * NARROW_W,
    localparam int PROD_W   = 2 * OP_W,
    localparam int PM_W     = 2 * MID_W,
    localparam int SUM_W    = PM_W + 2
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  dsp_clock_source_a,
    input  wire logic                  dsp_clock_source_b,
    input  wire logic                  dsp_clock_source_c,
    input  wire logic                  dsp_clock_source_d,
    input  wire logic                  fabric_ce,
    input  wire logic                  fabric_rst,
    input  wire dsp_pkg::width_mode_t  width_mode,
    input  wire logic                  sum_mode,
    input  wire logic                  in_reg_en,
    input  wire logic                  pipe_reg_en,
    input  wire logic                  out_reg_en,
    input  wire logic [1:0]            in_clk_sel,
    input  wire logic [1:0]            pipe_clk_sel,
    input  wire logic [1:0]            out_clk_sel,
    input  wire logic                  serial_load,
    input  wire logic [OP_W-1:0]       a_in,
    input  wire logic [OP_W-1:0]       b_in,
    input  wire logic                  a_signed,
    input  wire logic                  b_signed,
    input  wire logic                  addsub_01,
    input  wire logic                  addsub_23,
    output logic      [PROD_W-1:0]     result,
    output logic      [MID_W-1:0]      shift_out
);
    if (NARROW_W < 2)
    begin : g_bad_width
        $error("NARROW_W must be at least 2");
    end

    // Clock sources are resynchronised; a rising edge of the chosen one, gated by fabric_ce, is a stage tick.
    logic [dsp_pkg::CLK_SRC_N-1:0] src_raw;
    logic [dsp_pkg::CLK_SRC_N-1:0] src_m_r;
    logic [dsp_pkg::CLK_SRC_N-1:0] src_s_r;
    logic [dsp_pkg::CLK_SRC_N-1:0] src_d_r;
    logic [dsp_pkg::CLK_SRC_N-1:0] src_edge;
    logic                          in_tick;
    logic                          pipe_tick;
    logic                          out_tick;

    assign src_raw = {dsp_clock_source_d, dsp_clock_source_c,
                      dsp_clock_source_b, dsp_clock_source_a};

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            src_m_r <= '0;
            src_s_r <= '0;
            src_d_r <= '0;
        end
        else
        begin
            src_m_r <= src_raw;
            src_s_r <= src_m_r;
            src_d_r <= src_s_r;
        end
    end

    assign src_edge  = src_s_r & ~src_d_r;
    assign in_tick   = src_edge[in_clk_sel] & fabric_ce;
    assign pipe_tick = src_edge[pipe_clk_sel] & fabric_ce;
    assign out_tick  = src_edge[out_clk_sel] & fabric_ce;

    // Input stage.
    logic [OP_W-1:0]             a_r;
    logic [OP_W-1:0]             b_r;
    logic [dsp_pkg::CTL_W-1:0]   ctl_r;
    logic [OP_W-1:0]             a_nxt;
    logic [OP_W-1:0]             b_nxt;
    logic [OP_W-1:0]             a_s1;
    logic [OP_W-1:0]             b_s1;
    logic [dsp_pkg::CTL_W-1:0]   ctl_in;
    logic [dsp_pkg::CTL_W-1:0]   ctl_s1;

    assign ctl_in = {addsub_23, addsub_01, b_signed, a_signed};
    // Serial loading moves each lane up by one mid-width lane per tick.
    assign a_nxt = serial_load ? {a_r[OP_W-MID_W-1:0], a_in[MID_W-1:0]} : a_in;
    assign b_nxt = serial_load ? {b_r[OP_W-MID_W-1:0], b_in[MID_W-1:0]} : b_in;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            a_r   <= '0;
            b_r   <= '0;
            ctl_r <= '0;
        end
        else if (fabric_rst)
        begin
            a_r   <= '0;
            b_r   <= '0;
            ctl_r <= '0;
        end
        else if (in_tick)
        begin
            a_r   <= a_nxt;
            b_r   <= b_nxt;
            ctl_r <= ctl_in;
        end
    end

    assign a_s1      = in_reg_en ? a_r : a_in;
    assign b_s1      = in_reg_en ? b_r : b_in;
    assign ctl_s1    = in_reg_en ? ctl_r : ctl_in;
    assign shift_out = a_r[OP_W-1 -: MID_W];

    // Multiplier array: g=0 narrow lanes, g=1 mid lanes, g=2 the single wide lane.
    wire [PROD_W-1:0] prod_all [0:2];

    for (genvar g = 0; g < 3; g++)
    begin : g_width
        localparam int W = NARROW_W << g;
        localparam int N = (g == 2) ? 1 : (8 >> g);
        for (genvar i = 0; i < N; i++)
        begin : g_lane
            logic signed [W:0]     ea;
            logic signed [W:0]     eb;
            logic signed [2*W+1:0] full;
            assign ea   = {ctl_s1[dsp_pkg::CTL_SA] & a_s1[i*W+W-1], a_s1[i*W +: W]};
            assign eb   = {ctl_s1[dsp_pkg::CTL_SB] & b_s1[i*W+W-1], b_s1[i*W +: W]};
            assign full = ea * eb;
            assign prod_all[g][i*2*W +: 2*W] = full[2*W-1:0];
        end
        if (g == 2)
        begin : g_pad
            assign prod_all[g][PROD_W-1:2*WIDE_W] = '0;
        end
    end

    // Sum mode always uses the mid lanes. Width and element choice are not pipelined,
    // so changing them while data is in flight mixes formats for a few ticks.
    dsp_pkg::width_mode_t mode_eff;
    logic [PROD_W-1:0]    prod_s1;

    assign mode_eff = sum_mode ? dsp_pkg::WIDTH_MID : width_mode;

    always_comb
    begin
        case (mode_eff)
            dsp_pkg::WIDTH_WIDE:   prod_s1 = prod_all[2];
            dsp_pkg::WIDTH_MID:    prod_s1 = prod_all[1];
            dsp_pkg::WIDTH_NARROW: prod_s1 = prod_all[0];
            default:               prod_s1 = '0;
        endcase
    end

    // Pipeline stage.
    logic [PROD_W-1:0]           prod_r;
    logic [dsp_pkg::CTL_W-1:0]   ctl2_r;
    logic [PROD_W-1:0]           prod_s2;
    logic [dsp_pkg::CTL_W-1:0]   ctl_s2;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prod_r <= '0;
            ctl2_r <= '0;
        end
        else if (fabric_rst)
        begin
            prod_r <= '0;
            ctl2_r <= '0;
        end
        else if (pipe_tick)
        begin
            prod_r <= prod_s1;
            ctl2_r <= ctl_s1;
        end
    end

    assign prod_s2 = pipe_reg_en ? prod_r : prod_s1;
    assign ctl_s2  = pipe_reg_en ? ctl2_r : ctl_s1;

    // Pairwise add or subtract, then final sum; wraps modulo the sum width.
    logic                sum_sgn;
    logic [SUM_W-1:0]    lane_x [0:3];
    logic [SUM_W-1:0]    pair01;
    logic [SUM_W-1:0]    pair23;
    logic [SUM_W-1:0]    total;
    logic [PROD_W-1:0]   sum_ext;
    logic [PROD_W-1:0]   res_s2;

    assign sum_sgn = ctl_s2[dsp_pkg::CTL_SA] | ctl_s2[dsp_pkg::CTL_SB];

    for (genvar i = 0; i < 4; i++)
    begin : g_ext
        assign lane_x[i] = {{2{sum_sgn & prod_s2[i*PM_W+PM_W-1]}}, prod_s2[i*PM_W +: PM_W]};
    end

    assign pair01 = ctl_s2[dsp_pkg::CTL_AS01] ? lane_x[0] - lane_x[1]
                                              : lane_x[0] + lane_x[1];
    assign pair23 = ctl_s2[dsp_pkg::CTL_AS23] ? lane_x[2] - lane_x[3]
                                              : lane_x[2] + lane_x[3];
    assign total  = pair01 + pair23;
    assign sum_ext = {{(PROD_W-SUM_W){(sum_sgn | ctl_s2[dsp_pkg::CTL_AS01]
                     | ctl_s2[dsp_pkg::CTL_AS23]) & total[SUM_W-1]}}, total};
    assign res_s2 = sum_mode ? sum_ext : prod_s2;

    // Output stage. A bypassed output register makes result combinational.
    logic [PROD_W-1:0] result_r;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            result_r <= '0;
        end
        else if (fabric_rst)
        begin
            result_r <= '0;
        end
        else if (out_tick)
        begin
            result_r <= res_s2;
        end
    end

    assign result = out_reg_en ? result_r : res_s2;

    // Checking logic.
    logic             all_byp;
    logic [SUM_W-1:0] chk_p [0:3];
    logic [SUM_W-1:0] chk_sum;

    assign all_byp = !in_reg_en && !pipe_reg_en && !out_reg_en;
    for (genvar i = 0; i < 4; i++)
    begin : g_chk
        assign chk_p[i] = SUM_W'(a_in[i*MID_W +: MID_W]) * SUM_W'(b_in[i*MID_W +: MID_W]);
    end
    assign chk_sum = (addsub_01 ? chk_p[0] - chk_p[1] : chk_p[0] + chk_p[1])
                   + (addsub_23 ? chk_p[2] - chk_p[3] : chk_p[2] + chk_p[3]);

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    mid_bypass_product_a: assert property (
        all_byp && !sum_mode && width_mode == dsp_pkg::WIDTH_MID && !a_signed && !b_signed
        |-> result[3*PM_W +: PM_W] == a_in[3*MID_W +: MID_W] * b_in[3*MID_W +: MID_W])
        else $error("mid lane product wrong");
    narrow_lane_product_a: assert property (
        all_byp && !sum_mode && width_mode == dsp_pkg::WIDTH_NARROW && !a_signed && !b_signed
        |-> result[7*MID_W +: MID_W]
            == a_in[7*NARROW_W +: NARROW_W] * b_in[7*NARROW_W +: NARROW_W])
        else $error("narrow lane product wrong");
    wide_signed_product_a: assert property (
        all_byp && !sum_mode && width_mode == dsp_pkg::WIDTH_WIDE && a_signed && b_signed
        |-> $signed(result[2*WIDE_W-1:0])
            == $signed(a_in[WIDE_W-1:0]) * $signed(b_in[WIDE_W-1:0]))
        else $error("wide signed product wrong");
    pair_sum_value_a: assert property (
        all_byp && sum_mode && !a_signed && !b_signed |-> result[SUM_W-1:0] == chk_sum)
        else $error("four pair sum wrong");
    input_load_a: assert property (
        $rose(src_s_r[1]) && in_clk_sel == 2'h1 && fabric_ce && !fabric_rst && !serial_load
        |=> a_r == $past(a_in))
        else $error("input register missed selected edge");
    input_hold_a: assert property (
        !in_tick && !fabric_rst |=> $stable(a_r) && $stable(b_r))
        else $error("input register changed without tick");
    serial_shift_a: assert property (
        in_tick && serial_load && !fabric_rst
        |=> a_r[MID_W +: MID_W] == $past(a_r[MID_W-1:0])
            && a_r[MID_W-1:0] == $past(a_in[MID_W-1:0]))
        else $error("serial load did not shift");
    fabric_reset_clear_a: assert property (
        fabric_rst |=> a_r == '0 && prod_r == '0 && result_r == '0)
        else $error("fabric reset did not clear");
    out_hold_a: assert property (
        out_reg_en && !out_tick && !fabric_rst |=> $stable(result_r))
        else $error("output register changed without tick");

    sum_subtract_c: cover property (sum_mode && addsub_01 && addsub_23 && all_byp);
    full_pipe_c: cover property (in_reg_en && pipe_reg_en && out_reg_en && out_tick);
    serial_run_c: cover property (in_tick && serial_load ##[1:16] in_tick && serial_load);
    wide_mode_c: cover property (width_mode == dsp_pkg::WIDTH_WIDE && a_signed && !b_signed);
endmodule
`default_nettype wire

// >>> bench/fabric_clock_model.sv
`timescale 1ns/1ps
`default_nettype none
module fabric_clock_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] run,
    output logic      [3:0] src
);
    logic [2:0] phase_r;

    // Each source divides clk by eight, so every level lasts four cycles and the
    // slice's two-stage synchroniser cannot miss an edge. A stopped source rests low.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            phase_r <= 3'h0;
            src     <= 4'h0;
        end
        else
        begin
            phase_r <= phase_r + 3'h1;
            src     <= run & {4{phase_r[2]}};
        end
    end
endmodule
`default_nettype wire

// >>> bench/dsp_multiply_add_slice_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_multiply_add_slice_tb;
    logic                 clk = 1'b0;
    logic                 sys_rst = 1'b1;
    logic [3:0]           run = 4'hf;
    logic [3:0]           src;
    logic                 ce = 1'b1;
    logic                 frst = 1'b0;
    dsp_pkg::width_mode_t wm = dsp_pkg::WIDTH_WIDE;
    logic                 sm = 1'b0;
    logic [2:0]           ren = 3'h0;
    logic [1:0]           sel = 2'h0;
    logic                 ser = 1'b0;
    logic [71:0]          a = 72'h0;
    logic [71:0]          b = 72'h0;
    logic [3:0]           sg = 4'h0;
    logic [143:0]         res;
    logic [17:0]          so;
    int                   fails = 0;
    int                   n_checks = 0;
    wire                  any_src = |src;

    always #12.5 clk = ~clk;

    fabric_clock_model fabric_clock_model_inst (
        .clk(clk), .sys_rst(sys_rst), .run(run), .src(src)
    );

    dsp_multiply_add_slice dsp_multiply_add_slice_inst (
        .clk(clk), .sys_rst(sys_rst), .dsp_clock_source_a(src[0]),
        .dsp_clock_source_b(src[1]), .dsp_clock_source_c(src[2]), .dsp_clock_source_d(src[3]),
        .fabric_ce(ce), .fabric_rst(frst), .width_mode(wm), .sum_mode(sm),
        .in_reg_en(ren[0]), .pipe_reg_en(ren[1]), .out_reg_en(ren[2]),
        .in_clk_sel(sel), .pipe_clk_sel(sel), .out_clk_sel(sel), .serial_load(ser),
        .a_in(a), .b_in(b), .a_signed(sg[0]), .b_signed(sg[1]),
        .addsub_01(sg[2]), .addsub_23(sg[3]), .result(res), .shift_out(so)
    );

    function automatic logic signed [75:0] ext(logic [71:0] v, int w, logic s);
        logic signed [75:0] m;
        logic signed [75:0] e;
        m = 76'sh1 <<< w;
        e = $signed({4'h0, v}) & (m - 76'sh1);
        if (s && e[w-1])
            e = e - m;
        return e;
    endfunction

    function automatic logic signed [75:0] lp(int w, int i);
        return ext(a >> (w * i), w, sg[0]) * ext(b >> (w * i), w, sg[1]);
    endfunction

    function automatic logic [143:0] mul(int w, int n);
        logic [143:0] r;
        r = 144'h0;
        for (int i = 0; i < n; i++)
            r |= (144'(lp(w, i)) & ((144'h1 << (2 * w)) - 144'h1)) << (2 * w * i);
        return r;
    endfunction

    // Sum mode works on the four mid lanes; a signed or subtracting sum is sign-extended.
    function automatic logic [143:0] cur();
        logic signed [75:0] s;
        if (!sm)
            return mul(18, 4);
        s = (sg[2] ? lp(18, 0) - lp(18, 1) : lp(18, 0) + lp(18, 1))
          + (sg[3] ? lp(18, 2) - lp(18, 3) : lp(18, 2) + lp(18, 3));
        return (|sg) ? {{106{s[37]}}, s[37:0]} : {106'h0, s[37:0]};
    endfunction

    task automatic chk(string what, logic [143:0] exp, logic [143:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask

    // Ends a few cycles after a source rise, clear of the next stage capture.
    task automatic tick(int n);
        repeat (n)
        begin
            @(posedge any_src);
            repeat (5) @(posedge clk);
        end
        #1;
    endtask

    task automatic t_plain();
        for (int m = 0; m < 3; m++)
            for (int s = 0; s < 4; s++)
            begin
                @(posedge clk);
                wm <= dsp_pkg::width_mode_t'(3'h1 << m);
                sg <= 4'(s);
                @(posedge clk);
                #1;
                chk("product", mul(36 >> m, (m == 0) ? 1 : (2 << m)), res);
            end
    endtask

    task automatic t_sum();
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk);
            sm <= 1'b1;
            wm <= dsp_pkg::WIDTH_MID;
            sg <= {2'(k), k[2], k[2]};
            @(posedge clk);
            #1;
            chk("pair sum", cur(), res);
        end
    endtask

    task automatic t_pipe();
        logic [143:0] e;
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk);
            ren <= 3'h7;
            sm <= m[0];
            tick(4);
            e = cur();
            chk("filled", e, res);
            @(posedge clk);
            a <= ~a;
            sg <= ~sg;
            tick(2);
            chk("two ticks", e, res);
            tick(1);
            chk("three ticks", cur(), res);
        end
    endtask

    // One stage enabled at a time: it holds until its own tick, then follows.
    task automatic t_stage();
        logic [143:0] e;
        for (int r = 0; r < 3; r++)
        begin
            @(posedge clk);
            ren <= 3'h1 << r;
            tick(1);
            e = cur();
            @(posedge clk);
            b <= ~b;
            @(posedge clk);
            #1;
            chk("stage held", e, res);
            tick(1);
            chk("stage loaded", cur(), res);
        end
        @(posedge clk);
        ren <= 3'h7;
        tick(3);
    endtask

    task automatic t_hold();
        logic [143:0] e;
        e = cur();
        @(posedge clk);
        ce <= 1'b0;
        a <= {a[35:0], a[71:36]};
        tick(3);
        chk("held", e, res);
        @(posedge clk);
        frst <= 1'b1;
        @(posedge clk);
        frst <= 1'b0;
        #1;
        chk("cleared", 144'h0, res);
    endtask

    task automatic t_sel();
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk);
            ce <= 1'b1;
            frst <= 1'b1;
            sel <= 2'(s);
            run <= ~(4'h1 << s);
            @(posedge clk);
            frst <= 1'b0;
            tick(4);
            chk("unselected", 144'h0, res);
            @(posedge clk);
            run <= 4'h1 << s;
            tick(4);
            chk("selected", cur(), res);
        end
    endtask

    // The clear follows a settled tick, so no stray source edge shifts a stale lane in.
    task automatic t_serial();
        logic [143:0] e;
        @(posedge clk);
        run <= 4'hf;
        ser <= 1'b1;
        tick(1);
        @(posedge clk);
        frst <= 1'b1;
        @(posedge clk);
        frst <= 1'b0;
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk);
            a[17:0] <= 18'h2a5a0 + 18'(k);
            tick(1);
            e = (k < 3) ? 144'h0 : 144'(18'h2a5a0 + 18'(k - 3));
            chk("top lane", e, 144'(so));
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        a <= 72'h9f3a5c1e7790abcd12;
        b <= 72'h5e81b7c2f40d6a93e8;
        t_plain();
        t_sum();
        t_pipe();
        t_stage();
        t_hold();
        t_sel();
        t_serial();
        give_verdict();
    end
endmodule
`default_nettype wire
